// file: rtl/fpsg_top.sv
// Flash page security guard: APB registers, access classification,
// permission decision and the command handed to the flash engine.
// Assumes requests come from same-clock logic and that fault_reset_req
// is wired to the system reset generator, which then pulls rst_n.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "fpsg_regs.svh"
module fpsg_top
  import fpsg_pkg::*;
(
  input wire logic clk_sys, // System clock, 40 MHz
  input wire logic rst_n, // System reset, async, active low
  input wire logic por_n, // Power-on reset, async, active low
  // APB slave
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  // Access request
  input wire logic req_valid, // Access request
  input wire logic req_from_debug, // Request from debug port
  input wire fpsg_op_e req_op, // Requested operation
  input wire logic [`FPSG_ADDR_W-1:0] req_addr, // Target byte address
  input wire logic [`FPSG_ADDR_W-1:0] fetch_addr, // Firmware code address
  input wire logic [7:0] req_wdata, // Write data
  input wire logic [7:0] cur_byte, // Current flash byte at req_addr
  input wire logic [7:0] lock_byte_in, // Lock byte read from flash
  output logic req_grant, // Request allowed
  output logic req_refused, // Request ignored
  // Flash engine command
  output logic flash_cmd_valid, // Command pulse
  output fpsg_op_e flash_cmd_op, // Command operation
  output logic [`FPSG_ADDR_W-1:0] flash_cmd_addr, // Command address
  output logic [7:0] flash_cmd_wdata, // Command data
  // System
  output logic fault_reset_req, // Flash error reset request pulse
  output logic irq // Interrupt, level
);

  // ------------------------------------------------------------------
  // Lock byte capture
  // ------------------------------------------------------------------
  // The lock byte is caught once after reset release, so that a write
  // to it only takes effect after the next device reset.
  logic [7:0] lock_reg;
  logic lock_taken_reg;
  logic [7:0] lock_count;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= `FPSG_LOCK_RESET;
      lock_taken_reg <= 1'b0;
    end else if (!lock_taken_reg) begin
      lock_reg <= lock_byte_in;
      lock_taken_reg <= 1'b1;
    end
  end

  assign lock_count = ~lock_reg;

  // ------------------------------------------------------------------
  // Access classification and decision
  // ------------------------------------------------------------------
  function automatic logic [`FPSG_PAGE_W-1:0] page_of(
    input logic [`FPSG_ADDR_W-1:0] addr
  );
    page_of = addr[`FPSG_ADDR_W-1:`FPSG_PAGE_LSB];
  endfunction

  localparam logic [`FPSG_ADDR_W-1:0] LOCK_ADDR = `FPSG_LOCK_BYTE_ADDR;
  localparam logic [`FPSG_PAGE_W-1:0] LOCK_PAGE =
    LOCK_ADDR[`FPSG_ADDR_W-1:`FPSG_PAGE_LSB];

  // The lock byte page counts as locked as soon as any page is locked.
  // lock page follows
  function automatic logic page_is_locked(
    input logic [`FPSG_PAGE_W-1:0] page,
    input logic [7:0] count
  );
    logic is_lock_page;
    is_lock_page = (page == LOCK_PAGE);
    page_is_locked = ({4'h0, page} < count) ||
                     (is_lock_page && count != 8'h00);
  endfunction

  logic [7:0] psc_reg;
  logic wr_en;
  logic er_en;
  logic fetch_locked;
  fpsg_src_e src;
  fpsg_op_e eff_op;
  logic fw_blocked;
  fpsg_verdict_e verdict;
  logic ev_debug_refused;
  logic ev_fw_blocked;
  logic ev_fault;

  assign wr_en = psc_reg[`FPSG_PSC_WRITE_EN_BIT];
  assign er_en = psc_reg[`FPSG_PSC_ERASE_EN_BIT];
  // Code fetched from any locked page, the lock byte page included.
  assign fetch_locked = page_is_locked(page_of(fetch_addr), lock_count);

  assign src = req_from_debug ? FPSG_SRC_DEBUG :
               fetch_locked ? FPSG_SRC_FW_LOCKED : FPSG_SRC_FW_UNLOCKED;

  assign eff_op = (!req_from_debug && req_op != FPSG_OP_READ &&
                   wr_en && er_en) ? FPSG_OP_ERASE : req_op;

  assign fw_blocked = !req_from_debug && req_op != FPSG_OP_READ &&
                      (!wr_en || (req_op == FPSG_OP_ERASE && !er_en));

  fpsg_decide u_decide (
    .src(src),
    .op(eff_op),
    .page(page_of(req_addr)),
    .lock_count(lock_count),
    .verdict(verdict)
  );

  assign req_grant = req_valid && !fw_blocked && verdict == FPSG_ALLOW;
  assign req_refused = req_valid && !req_grant && !ev_fault;
  assign ev_debug_refused = req_valid && req_from_debug &&
                            verdict == FPSG_REFUSE;
  assign ev_fw_blocked = req_valid && fw_blocked;
  assign ev_fault = req_valid && !req_from_debug && !fw_blocked &&
                    verdict == FPSG_FAULT;

  // ------------------------------------------------------------------
  // Flash engine command
  // ------------------------------------------------------------------
  logic [`FPSG_ADDR_W-1:0] cmd_addr_next;
  logic [7:0] cmd_wdata_next;

  assign cmd_addr_next = (eff_op == FPSG_OP_ERASE) ?
    {page_of(req_addr), {`FPSG_PAGE_LSB{1'b0}}} : req_addr;
  assign cmd_wdata_next = (eff_op == FPSG_OP_ERASE) ? 8'hFF :
                          (eff_op == FPSG_OP_WRITE) ? (req_wdata & cur_byte) :
                          8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flash_cmd_valid <= 1'b0;
      flash_cmd_op <= FPSG_OP_READ;
      flash_cmd_addr <= '0;
      flash_cmd_wdata <= 8'h00;
      fault_reset_req <= 1'b0;
    end else begin
      flash_cmd_valid <= req_grant;
      fault_reset_req <= ev_fault;
      if (req_grant) begin
        flash_cmd_op <= eff_op;
        flash_cmd_addr <= cmd_addr_next;
        flash_cmd_wdata <= cmd_wdata_next;
      end
    end
  end

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  function automatic logic hits(input logic [11:0] a, input logic [7:0] idx);
    hits = (a == {2'b00, idx, 2'b00});
  endfunction

  logic hit_psc;
  logic hit_status;
  logic hit_mask;
  logic hit_lock;
  logic hit_cause;
  logic mapped;
  logic wr_acc;
  logic setup_rd;
  logic [31:0] rd_mux;

  assign hit_psc = hits(paddr, `FPSG_IDX_PROGRAM_STORE_CONTROL);
  assign hit_status = hits(paddr, `FPSG_IDX_EVENT_STATUS);
  assign hit_mask = hits(paddr, `FPSG_IDX_EVENT_MASK);
  assign hit_lock = hits(paddr, `FPSG_IDX_LOCK_VIEW);
  assign hit_cause = hits(paddr, `FPSG_IDX_RESET_CAUSE);
  assign mapped = hit_psc || hit_status || hit_mask || hit_lock || hit_cause;
  assign wr_acc = psel && penable && pwrite && mapped;
  assign setup_rd = psel && !penable && !pwrite;

  // Zero wait states: the read word is caught in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  logic [7:0] psc_next;

  assign psc_next = {6'h00, pwdata[`FPSG_PSC_ERASE_EN_BIT],
                     pwdata[`FPSG_PSC_WRITE_EN_BIT]};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      psc_reg <= `FPSG_PSC_RESET;
    end else if (wr_acc && hit_psc) begin
      psc_reg <= psc_next;
    end
  end

  // ------------------------------------------------------------------
  // Event status and mask
  // ------------------------------------------------------------------
  logic [`FPSG_EV_WIDTH-1:0] status_reg;
  logic [`FPSG_EV_WIDTH-1:0] mask_reg;
  logic [`FPSG_EV_WIDTH-1:0] ev_now;
  logic [`FPSG_EV_WIDTH-1:0] status_clr;
  logic [`FPSG_EV_WIDTH-1:0] status_next;

  assign ev_now = {ev_fault, ev_fw_blocked, ev_debug_refused};
  assign status_clr = (wr_acc && hit_status) ?
    pwdata[`FPSG_EV_WIDTH-1:0] : `FPSG_EV_RESET;
  // New events win over a write-one clear in the same cycle.
  assign status_next = (status_reg & ~status_clr) | ev_now;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= `FPSG_EV_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= `FPSG_EV_RESET;
    end else if (wr_acc && hit_mask) begin
      mask_reg <= pwdata[`FPSG_EV_WIDTH-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Reset cause flag
  // ------------------------------------------------------------------
  logic cause_reg;

  // Survives the fault reset it announces; power-on or a write of one to the bit clears it.
  // flag after reset
  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) begin
      cause_reg <= 1'b0;
    end else if (ev_fault) begin
      cause_reg <= 1'b1;
    end else if (wr_acc && hit_cause &&
                 pwdata[`FPSG_CAUSE_FLASH_FAULT_BIT]) begin
      cause_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Read data and interrupt
  // ------------------------------------------------------------------
  // lock page state shown
  assign rd_mux = hit_psc ? {24'h0, psc_reg} :
                  hit_status ? {29'h0, status_reg} :
                  hit_mask ? {29'h0, mask_reg} :
                  hit_lock ? {15'h0, lock_count != 8'h00, lock_count,
                              lock_reg} :
                  hit_cause ? {31'h0, cause_reg} : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end

  assign irq = |(status_reg & mask_reg);

endmodule // fpsg_top

// file: rtl/fpsg_regs.svh
// Register offsets, field positions, reset values and fixed addresses of
// the flash page security guard. Assumes a 13-bit byte address (8 kB).
`ifndef FPSG_REGS_SVH
`define FPSG_REGS_SVH

// Register indices; the APB byte address is four times the index.
`define FPSG_IDX_PROGRAM_STORE_CONTROL 8'h8F
`define FPSG_IDX_EVENT_STATUS 8'h90
`define FPSG_IDX_EVENT_MASK 8'h91
`define FPSG_IDX_LOCK_VIEW 8'h92
`define FPSG_IDX_RESET_CAUSE 8'h93

// Fields of program_store_control.
`define FPSG_PSC_WRITE_EN_BIT 0
`define FPSG_PSC_ERASE_EN_BIT 1
`define FPSG_PSC_RESET 8'h00

// Event bits shared by status and mask.
`define FPSG_EV_DEBUG_REFUSED 0
`define FPSG_EV_FW_NOT_ENABLED 1
`define FPSG_EV_FAULT_RESET 2
`define FPSG_EV_WIDTH 3
`define FPSG_EV_RESET 3'h0

// Field of reset_cause_register.
`define FPSG_CAUSE_FLASH_FAULT_BIT 0

// Flash geometry: 512-byte pages, 16 pages.
`define FPSG_ADDR_W 13
`define FPSG_PAGE_LSB 9
`define FPSG_PAGE_W 4
`define FPSG_PAGE_BYTES 512

// Fixed location of the security lock byte (last byte of flash).
`define FPSG_LOCK_BYTE_ADDR 13'h1FFF
`define FPSG_LOCK_RESET 8'hFF

`endif

// file: rtl/fpsg_pkg.sv
// Types of the flash page security guard.
// Assumes nothing beyond the constants header.
package fpsg_pkg;

  typedef enum logic [1:0] {
    FPSG_OP_READ,
    FPSG_OP_WRITE,
    FPSG_OP_ERASE
  } fpsg_op_e;

  typedef enum logic [1:0] {
    FPSG_SRC_DEBUG,
    FPSG_SRC_FW_UNLOCKED,
    FPSG_SRC_FW_LOCKED
  } fpsg_src_e;

  typedef enum logic [1:0] {
    FPSG_ALLOW,
    FPSG_REFUSE,
    FPSG_FAULT
  } fpsg_verdict_e;

endpackage

// file: rtl/fpsg_decide.sv
// Combinational permission decision for one flash access.
// Assumes the caller has already classified the access source.
`timescale 1ns/1ps
`include "fpsg_regs.svh"
module fpsg_decide
  import fpsg_pkg::*;
(
  input wire fpsg_src_e src, // Access class
  input wire fpsg_op_e op, // Operation after enable mapping
  input wire logic [`FPSG_PAGE_W-1:0] page, // Target page
  input wire logic [7:0] lock_count, // Number of locked pages
  output fpsg_verdict_e verdict // Decision
);

  localparam logic [`FPSG_ADDR_W-1:0] LOCK_ADDR = `FPSG_LOCK_BYTE_ADDR;
  localparam logic [`FPSG_PAGE_W-1:0] LOCK_PAGE =
    LOCK_ADDR[`FPSG_ADDR_W-1:`FPSG_PAGE_LSB];

  logic tgt_lock_page;
  logic any_locked;
  logic page_locked;

  assign tgt_lock_page = (page == LOCK_PAGE);
  assign any_locked = (lock_count != 8'h00);
  assign page_locked = ({4'h0, page} < lock_count);

  always_comb begin
    verdict = FPSG_ALLOW;
    if (tgt_lock_page) begin
      if (!any_locked) begin
        verdict = FPSG_ALLOW;
      end else if (src == FPSG_SRC_DEBUG) begin
        verdict = FPSG_REFUSE;
      end else if (src == FPSG_SRC_FW_UNLOCKED) begin
        verdict = FPSG_FAULT;
      end else if (op == FPSG_OP_ERASE) begin
        verdict = FPSG_FAULT;
      end else begin
        verdict = FPSG_ALLOW;
      end
    end else if (page_locked) begin
      if (src == FPSG_SRC_DEBUG) begin
        verdict = FPSG_REFUSE;
      end else if (src == FPSG_SRC_FW_UNLOCKED) begin
        verdict = FPSG_FAULT;
      end else begin
        verdict = FPSG_ALLOW;
      end
    end else begin
      verdict = FPSG_ALLOW;
    end
  end

endmodule // fpsg_decide

// file: verif/fpsg_props.sv
// Port assertions for the flash page security guard.
// Bound onto fpsg_top; sees only its ports.
`timescale 1ns/1ps
`include "fpsg_regs.svh"
module fpsg_props
  import fpsg_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic [11:0] paddr, // Address
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic req_valid, // Request
  input wire logic req_from_debug, // Source
  input wire logic [`FPSG_ADDR_W-1:0] req_addr, // Target
  input wire logic [7:0] req_wdata, // Data
  input wire logic [7:0] cur_byte, // Old byte
  input wire logic req_grant, // Grant
  input wire logic req_refused, // Refusal
  input wire logic flash_cmd_valid, // Command
  input wire fpsg_op_e flash_cmd_op, // Operation
  input wire logic [`FPSG_ADDR_W-1:0] flash_cmd_addr, // Address
  input wire logic [7:0] flash_cmd_wdata, // Data
  input wire logic fault_reset_req // Fault
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  wire mapped = paddr >= 12'h23C && paddr <= 12'h24C && paddr[1:0] == 2'h0;
  a_grant_alone: assert property (
    req_valid |-> !(req_grant && req_refused))
    else $error("grant and refusal together");
  a_cmd_follows: assert property (
    req_valid && req_grant |=> flash_cmd_valid)
    else $error("granted request gave no command");
  a_cmd_cause: assert property (
    flash_cmd_valid |-> $past(req_valid && req_grant))
    else $error("command without a grant");
  a_debug_quiet: assert property (
    req_valid && req_from_debug |=> !fault_reset_req)
    else $error("debug access caused a fault reset");
  a_fault_cause: assert property (
    fault_reset_req |-> $past(req_valid && !req_from_debug &&
    !req_grant && !req_refused))
    else $error("fault reset without a forbidden firmware access");
  a_erase_page: assert property (
    flash_cmd_valid && flash_cmd_op == FPSG_OP_ERASE |->
    flash_cmd_wdata == 8'hFF && flash_cmd_addr[8:0] == 9'h000)
    else $error("erase not page aligned or not all ones");
  a_write_clears: assert property (
    flash_cmd_valid && flash_cmd_op == FPSG_OP_WRITE |->
    flash_cmd_wdata == $past(req_wdata & cur_byte) &&
    flash_cmd_addr == $past(req_addr))
    else $error("write command sets bits or moved");
  a_apb_answer: assert property (
    psel && penable |-> pready && pslverr == !mapped)
    else $error("bus answer wrong");
  c_erase: cover property (flash_cmd_valid && flash_cmd_op == FPSG_OP_ERASE);
  c_fault: cover property (fault_reset_req);
  c_refuse: cover property (req_valid && req_refused);
endmodule // fpsg_props

// file: verif/fpsg_flash_model.sv
// Behavioural flash array behind the guard's command port.
// Assumes commands arrive as one-cycle pulses on clk_sys.
`timescale 1ns/1ps
`include "fpsg_regs.svh"
module fpsg_flash_model
  import fpsg_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic flash_cmd_valid, // Command pulse
  input wire fpsg_op_e flash_cmd_op, // Operation
  input wire logic [12:0] flash_cmd_addr, // Address
  input wire logic [7:0] flash_cmd_wdata, // Data
  input wire logic [12:0] req_addr, // Lookup address
  output logic [7:0] cur_byte, // Byte at req_addr
  output logic [7:0] lock_byte_in // Stored lock byte
);
  logic [7:0] mem [8192];
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'hFF;
    end
  end
  assign cur_byte = mem[req_addr];
  assign lock_byte_in = mem[`FPSG_LOCK_BYTE_ADDR];
  always @(posedge clk_sys) begin
    if (flash_cmd_valid && flash_cmd_op == FPSG_OP_WRITE) begin
      mem[flash_cmd_addr] <= mem[flash_cmd_addr] & flash_cmd_wdata;
    end
    for (int i = 0; i < 512; i++) begin
      if (flash_cmd_valid && flash_cmd_op == FPSG_OP_ERASE) begin
        mem[{flash_cmd_addr[12:9], 9'(i)}] <= 8'hFF;
      end
    end
  end
endmodule // fpsg_flash_model

// file: verif/tb_top.sv
// Self-checking bench for the flash page security guard.
// Assumes the flash model answers byte lookups at once.
`timescale 1ns/1ps
`include "fpsg_regs.svh"
module tb_top
  import fpsg_pkg::*;
;
  logic clk_sys = 0, rst_n = 0, por_n = 0, psel = 0, penable = 0;
  logic pwrite = 0, req_valid = 0, req_from_debug = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, req_grant, req_refused, flash_cmd_valid;
  logic fault_reset_req, irq, pv = 0;
  fpsg_op_e req_op = FPSG_OP_READ, flash_cmd_op;
  logic [12:0] req_addr = 13'h0, fetch_addr = 13'h0, flash_cmd_addr, a;
  logic [7:0] req_wdata = 8'h0, cur_byte, lock_byte_in, flash_cmd_wdata;
  logic [3:0] pend, q[$];
  int errors = 0, checks = 0;
  localparam logic [3:0] PG [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
  always #12.5 clk_sys = ~clk_sys;
  fpsg_top i_fpsg_top (.clk_sys, .rst_n, .por_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_from_debug,
    .req_op, .req_addr, .fetch_addr, .req_wdata, .cur_byte, .lock_byte_in,
    .req_grant, .req_refused, .flash_cmd_valid, .flash_cmd_op,
    .flash_cmd_addr, .flash_cmd_wdata, .fault_reset_req, .irq);
  fpsg_flash_model i_fpsg_flash_model (.clk_sys, .flash_cmd_valid,
    .flash_cmd_op, .flash_cmd_addr, .flash_cmd_wdata, .req_addr, .cur_byte,
    .lock_byte_in);
  task automatic chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] i,
    input logic [31:0] d, output logic [31:0] r);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] r;
    apb(1, i, d, r);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] r;
    apb(0, i, 32'h0, r);
    chk(r, e);
  endtask
  task automatic rq(input logic dbg, input fpsg_op_e op,
    input logic [12:0] ad, f, input logic [7:0] d, input logic [3:0] e);
    req_valid <= 1;
    req_from_debug <= dbg;
    req_op <= op;
    req_addr <= ad;
    fetch_addr <= f;
    req_wdata <= d;
    q.push_back(e);
    @(posedge clk_sys);
  endtask
  task automatic rq_end;
    req_valid <= 0;
    @(posedge clk_sys);
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk_sys);
    chk(irq, e);
    @(posedge clk_sys);
  endtask
  function automatic logic [3:0] ex(input logic dbg, input logic [3:0] pg,
    fp, input int n);
    logic lk, lf;
    lk = (n != 0 && pg == 4'hF) || pg < n;
    lf = (n != 0 && fp == 4'hF) || fp < n;
    if (!lk || (!dbg && lf)) return 4'b1000;
    return dbg ? 4'b0100 : 4'b0010;
  endfunction
  always @(posedge clk_sys) begin
    if (pv) begin
      chk({flash_cmd_valid, fault_reset_req, flash_cmd_valid &&
        flash_cmd_op == FPSG_OP_ERASE}, {pend[3], pend[1], pend[0]});
    end
    pv = req_valid;
    if (req_valid) begin
      pend = q.pop_front();
      chk({req_grant, req_refused}, pend[3:2]);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    wrap_up;
  end
  initial begin
    void'($urandom(29));
    repeat (16) @(posedge clk_sys);
    por_n <= 1;
    rst_n <= 1;
    repeat (2) @(posedge clk_sys);
    rd(8'h8F, 32'h0);
    rd(8'h92, 32'hFF);
    rd(8'h80, 32'h0);
    rq(0, FPSG_OP_WRITE, 13'h0600, 13'h0A00, 8'h00, 4'b0100);
    rq_end;
    rd(8'h90, 32'h2);
    irq_is(0);
    wr(8'h91, 32'h2);
    irq_is(1);
    wr(8'h90, 32'h2);
    irq_is(0);
    wr(8'h8F, 32'h1);
    for (int i = 0; i < 6; i++) begin
      a = 13'($urandom_range(13'h1DFF));
      rq(i[0], FPSG_OP_WRITE, a, a, 8'($urandom), 4'b1000);
    end
    rq_end;
    wr(8'h8F, 32'h3);
    rq(0, FPSG_OP_WRITE, 13'h0400, 13'h0800, 8'h00, 4'b1001);
    rq(1, FPSG_OP_ERASE, 13'h0A00, 13'h0, 8'h00, 4'b1001);
    rq_end;
    wr(8'h8F, 32'h1);
    rq(1, FPSG_OP_READ, 13'h1FFF, 13'h0, 8'h00, 4'b1000);
    rq(0, FPSG_OP_WRITE, 13'h1FFF, 13'h0800, 8'hFD, 4'b1000);
    rq_end;
    rst_n <= 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    repeat (2) @(posedge clk_sys);
    rd(8'h92, 32'h0001_02FD);
    wr(8'h8F, 32'h1);
    for (int i = 0; i < 4; i++) begin
      for (int s = 0; s < 3; s++) begin
        rq(s == 0, fpsg_op_e'($urandom_range(1)), {PG[i], 7'h2A, 2'(s)},
          {s == 2 ? 4'h0 : 4'h5, 9'h000}, 8'($urandom),
          ex(s == 0, PG[i], s == 2 ? 4'h0 : 4'h5, 2));
      end
    end
    rq(0, FPSG_OP_READ, 13'h00A0, 13'h1F00, 8'h00, 4'b1000);
    rq_end;
    wr(8'h8F, 32'h3);
    rq(0, FPSG_OP_WRITE, 13'h1E00, 13'h0000, 8'h00, 4'b0010);
    rq_end;
    rd(8'h90, 32'h5);
    rst_n <= 0;
    @(posedge clk_sys);
    rst_n <= 1;
    repeat (2) @(posedge clk_sys);
    rd(8'h93, 32'h1);
    wr(8'h93, 32'h1);
    rd(8'h93, 32'h0);
    wrap_up;
  end
endmodule // tb_top
bind fpsg_top fpsg_props i_fpsg_props (.clk_sys, .rst_n, .psel, .penable,
  .paddr, .pready, .pslverr, .req_valid, .req_from_debug, .req_addr,
  .req_wdata, .cur_byte, .req_grant, .req_refused, .flash_cmd_valid,
  .flash_cmd_op, .flash_cmd_addr, .flash_cmd_wdata, .fault_reset_req);
